/* File: hdl/adc_ctrl_pkg.sv */
/*
  Constants for the converter start and readout control block.
  Assumes a 200 MHz system clock; all cycle counts are derived from times.
*/
package adc_ctrl_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 20000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DCLK_HALF_NS = 550;
  localparam int DCLK_HALF_CYCLES = (DCLK_HALF_NS * CLK_MHZ) / 1000;
  localparam int CLK_START_NS = 1400;
  localparam int CLK_START_CYCLES = (CLK_START_NS * CLK_MHZ) / 1000;
  localparam int RESULT_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int NUM_CHANNELS = 4;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [1:0] CHANNEL_RESET = 2'h0;
  localparam int FRAME_PIN = 3;
  localparam int SERIAL_PIN = 1;
  localparam int CHAIN_PIN = 0;
  localparam int CLOCK_PIN = 2;
  localparam int SOURCE_PIN = 4;
endpackage : adc_ctrl_pkg

/* File: hdl/adc_convert_read_control.sv */
/*
  Conversion start and result readout control, parallel and serial.
  Assumes strobes are asynchronous pins; the external data clock arrives
  as its own clock domain and runs only while a read is enabled.
*/
`timescale 1ns/1ps
module adc_convert_read_control #(
  parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic data_shift_clock,
  input wire logic chipSelectN,
  input wire logic readConvert,
  input wire logic byteSelect,
  input wire logic output_format_select,
  input wire logic continuous_mode,
  input wire logic power_down,
  input wire logic [15:0] sampleData,
  input wire logic channel_addr_hi_in,
  input wire logic channel_addr_lo_in,
  output logic channel_addr_hi_out,
  output logic channel_addr_lo_out,
  output logic channelAddrOe,
  input wire logic [7:0] parallelDataIn,
  output logic [7:0] parallel_data_bus,
  output logic [7:0] parallelDataOe,
  output logic busyN,
  output logic [1:0] sampleChannel
);
  localparam int HALF = adc_ctrl_pkg::DCLK_HALF_CYCLES;
  localparam int LEAD = adc_ctrl_pkg::CLK_START_CYCLES;
  typedef enum {IDLE, CONVERT} conv_e;

  // Input synchronisers
  logic [1:0] csSync, rcSync, fmtSync, conSync, pdSync, srcSync, chainSync, bsSync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csSync <= 2'h3;
      rcSync <= 2'h3;
      fmtSync <= 2'h0;
      conSync <= 2'h0;
      pdSync <= 2'h0;
      srcSync <= 2'h0;
      chainSync <= 2'h0;
      bsSync <= 2'h0;
    end else begin
      csSync <= {csSync[0], chipSelectN};
      rcSync <= {rcSync[0], readConvert};
      fmtSync <= {fmtSync[0], output_format_select};
      conSync <= {conSync[0], continuous_mode};
      pdSync <= {pdSync[0], power_down};
      srcSync <= {srcSync[0], parallelDataIn[adc_ctrl_pkg::SOURCE_PIN]};
      chainSync <= {chainSync[0], parallelDataIn[adc_ctrl_pkg::CHAIN_PIN]};
      bsSync <= {bsSync[0], byteSelect};
    end
  end
  logic [1:0] addrSync0, addrSync1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrSync0 <= 2'h0;
      addrSync1 <= 2'h0;
    end else begin
      addrSync0 <= {channel_addr_hi_in, channel_addr_lo_in};
      addrSync1 <= addrSync0;
    end
  end

  wire logic cs = csSync[1];
  wire logic rc = rcSync[1];
  wire logic parMode = fmtSync[1];
  wire logic extClk = srcSync[1];
  wire logic contMode = conSync[1] & ~parMode;

  // Delayed strobes for edge detection
  logic csD, rcD;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csD <= 1'b1;
      rcD <= 1'b1;
    end else begin
      csD <= cs;
      rcD <= rc;
    end
  end
  wire logic combined = cs | rc;
  wire logic combinedD = csD | rcD;
  wire logic convCmd = combinedD & ~combined;
  wire logic readEn = rc & ~cs;

  // Conversion sequencer
  conv_e state;
  logic [31:0] convCount;
  logic [15:0] result;
  logic [15:0] prevResult;
  logic intSerial;
  logic [4:0] bitsLeft;
  logic [15:0] halfCount;
  logic [15:0] shiftReg;
  logic intClk;
  logic tagLatch;
  logic serialActive;
  wire logic startNow = (state == IDLE) && !pdSync[1]
    && (convCmd || (contMode && !combined));
  wire logic convDone = (state == CONVERT) && (convCount == 32'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      convCount <= 32'h0;
    end else begin
      case (state)
        IDLE: begin
          if (startNow) begin
            state <= CONVERT;
            convCount <= 32'(CONV_CYCLES - 1);
          end
        end
        CONVERT: begin
          if (convCount != 32'h0) begin
            convCount <= convCount - 32'h1;
          end else if (!intSerial || bitsLeft == 5'h0) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Result register: loaded at conversion end, held in power down
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result <= adc_ctrl_pkg::RESULT_RESET;
    end else if (convDone && !pdSync[1]) begin
      result <= sampleData;
    end
  end
  assign prevResult = result;

  // Busy output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busyN <= 1'b1;
    end else begin
      busyN <= !(startNow || (state == CONVERT && !(convDone
        && (!intSerial || bitsLeft == 5'h0))));
    end
  end

  // Channel selection and continuous cycling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sampleChannel <= adc_ctrl_pkg::CHANNEL_RESET;
    end else if (contMode && pdSync[1]) begin
      sampleChannel <= adc_ctrl_pkg::CHANNEL_RESET;
    end else if (startNow) begin
      if (contMode) begin
        sampleChannel <= sampleChannel + 2'h1;
      end else begin
        sampleChannel <= addrSync1;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_addr_hi_out <= 1'b0;
      channel_addr_lo_out <= 1'b0;
      channelAddrOe <= 1'b0;
    end else begin
      channel_addr_hi_out <= sampleChannel[1];
      channel_addr_lo_out <= sampleChannel[0];
      channelAddrOe <= contMode;
    end
  end

  // Internal data clock generator and shifter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intSerial <= 1'b0;
      bitsLeft <= 5'h0;
      halfCount <= 16'h0;
      shiftReg <= 16'h0;
      intClk <= 1'b0;
      tagLatch <= 1'b0;
    end else if (startNow && !parMode && !extClk) begin
      intSerial <= 1'b1;
      bitsLeft <= 5'(adc_ctrl_pkg::RESULT_BITS);
      halfCount <= 16'(LEAD);
      shiftReg <= prevResult;
      intClk <= 1'b0;
    end else if (intSerial && bitsLeft != 5'h0) begin
      if (halfCount != 16'h0) begin
        halfCount <= halfCount - 16'h1;
      end else begin
        halfCount <= 16'(HALF - 1);
        intClk <= ~intClk;
        if (intClk) begin
          bitsLeft <= bitsLeft - 5'h1;
          if (bitsLeft == 5'(adc_ctrl_pkg::RESULT_BITS)) begin
            tagLatch <= chainSync[1];
          end
          if (bitsLeft == 5'h1) begin
            shiftReg <= {16{tagLatch}};
          end else begin
            shiftReg <= {shiftReg[14:0], 1'b0};
          end
        end
      end
    end else if (state == IDLE) begin
      intSerial <= 1'b0;
      intClk <= 1'b0;
    end
  end

  // External data clock domain: capture result and shift on clock
  logic [1:0] extEnSync;
  logic [15:0] extShift;
  logic extFrame;
  logic extFirst;
  always_ff @(posedge data_shift_clock or negedge resetn) begin
    if (!resetn) begin
      extEnSync <= 2'h0;
    end else begin
      extEnSync <= {extEnSync[0], serialActive};
    end
  end
  // Result word is stable while a read is enabled, so it is sampled directly
  always_ff @(posedge data_shift_clock or negedge resetn) begin
    if (!resetn) begin
      extShift <= 16'h0;
      extFrame <= 1'b0;
      extFirst <= 1'b0;
    end else if (!extEnSync[1]) begin
      extShift <= result;
      extFrame <= 1'b0;
      extFirst <= 1'b1;
    end else if (extFirst) begin
      extFrame <= 1'b1;
      extFirst <= 1'b0;
    end else begin
      extFrame <= 1'b0;
      extShift <= {extShift[14:0], parallelDataIn[adc_ctrl_pkg::CHAIN_PIN]};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialActive <= 1'b0;
    end else begin
      serialActive <= readEn && !parMode && extClk;
    end
  end

  // Pad drive: parallel bus or serial pin functions
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parallel_data_bus <= 8'h00;
      parallelDataOe <= 8'h00;
    end else if (parMode) begin
      parallel_data_bus <= bsSync[1] ? result[7:0] : result[15:8];
      parallelDataOe <= readEn ? 8'hff : 8'h00;
    end else begin
      parallel_data_bus <= 8'h00;
      parallelDataOe <= 8'h00;
      parallelDataOe[adc_ctrl_pkg::FRAME_PIN] <= 1'b1;
      parallel_data_bus[adc_ctrl_pkg::FRAME_PIN] <= extClk & extFrame;
      parallelDataOe[adc_ctrl_pkg::CLOCK_PIN] <= ~extClk;
      parallel_data_bus[adc_ctrl_pkg::CLOCK_PIN] <= intClk;
      if (extClk) begin
        parallel_data_bus[adc_ctrl_pkg::SERIAL_PIN] <= extShift[15];
        parallelDataOe[adc_ctrl_pkg::SERIAL_PIN] <= serialActive;
      end else begin
        parallel_data_bus[adc_ctrl_pkg::SERIAL_PIN] <= shiftReg[15];
        parallelDataOe[adc_ctrl_pkg::SERIAL_PIN] <= intSerial;
      end
    end
  end
endmodule : adc_convert_read_control

/* File: dv/adc_convert_read_control_assertions.sv */
/* Port checker for the convert/read control block.
   Bound into the block; strobes come from an outside host. */
`timescale 1ns/1ps
module adc_convert_read_control_assertions #(
  parameter int CONV_CYCLES = 50
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic readConvert,
  input wire logic output_format_select,
  input wire logic continuous_mode,
  input wire logic power_down,
  input wire logic channel_addr_hi_out,
  input wire logic channel_addr_lo_out,
  input wire logic channelAddrOe,
  input wire logic [7:0] parallelDataOe,
  input wire logic busyN
);
  int lowCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Strobe states, an idle condition and a taken command
  sequence rdOn; output_format_select && !chipSelectN && readConvert; endsequence
  sequence rdOff; output_format_select && (chipSelectN || !readConvert); endsequence
  sequence idle; busyN && !power_down && !continuous_mode; endsequence
  sequence fire; (chipSelectN || readConvert) ##1 (!chipSelectN && !readConvert); endsequence
  // Length of the current busy interval
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lowCnt <= 0;
    else lowCnt <= busyN ? 0 : lowCnt + 1;
  end
  a_bus_driven: assert property (rdOn [*5] |-> parallelDataOe == 8'hff)
    else $error("parallel bus not driven");
  a_bus_released: assert property (rdOff [*5] |-> parallelDataOe == 8'h00)
    else $error("parallel bus driven while deselected");
  a_start_taken: assert property (idle [*6] ##0 fire |-> ##[1:5] !busyN)
    else $error("conversion not started");
  a_busy_min: assert property ($fell(busyN) |-> !busyN [*8])
    else $error("busy pulse too short");
  a_busy_length: assert property ($rose(busyN) && output_format_select |->
    lowCnt inside {[CONV_CYCLES - 3:CONV_CYCLES + 3]}) else $error("busy length wrong");
  a_pd_hold: assert property ((power_down && busyN) [*8] |=> busyN)
    else $error("conversion during power down");
  a_pd_channel: assert property ((continuous_mode && power_down) [*6] |->
    !channel_addr_hi_out && !channel_addr_lo_out) else $error("channel not reset");
  a_addr_out: assert property (continuous_mode [*4] |-> channelAddrOe)
    else $error("address pins not driven");
  a_addr_in: assert property ((!continuous_mode) [*4] |-> !channelAddrOe)
    else $error("address pins driven as inputs");
  a_serial_pins: assert property ((!output_format_select) [*5] |->
    parallelDataOe[7:5] == 3'h0 && parallelDataOe[3] && !parallelDataOe[0])
    else $error("serial pin directions wrong");
endmodule : adc_convert_read_control_assertions

bind adc_convert_read_control adc_convert_read_control_assertions #(
  .CONV_CYCLES(CONV_CYCLES)) chk_u (.clk(clk), .resetn(resetn), .chipSelectN(chipSelectN),
  .readConvert(readConvert), .output_format_select(output_format_select),
  .continuous_mode(continuous_mode), .power_down(power_down),
  .channel_addr_hi_out(channel_addr_hi_out), .channel_addr_lo_out(channel_addr_lo_out),
  .channelAddrOe(channelAddrOe), .parallelDataOe(parallelDataOe), .busyN(busyN));

/* File: dv/serial_reader_model.sv */
/* Host serial reader: supplies the external data clock in frames
   and collects the result stream. Assumes a 15 ns clock period. */
`timescale 1ns/1ps
module serial_reader_model (
  input wire logic frame,
  input wire logic sdat,
  output logic data_shift_clock,
  output logic chain,
  output logic [15:0] word
);
  int seen;
  initial begin
    data_shift_clock = 1'b0;
    chain = 1'b1;
    word = 16'h0000;
  end
  // One frame; clock idles low between frames, data taken before fall
  task automatic frameRun(input int n);
    seen = -1;
    word = 16'h0000;
    #3.3;
    repeat (n) begin
      #7.5 data_shift_clock = 1'b1;
      #7.5;
      // Frame pulse marks the clock that carries the MSB, so take it at once
      if (frame && seen < 0) seen = 0;
      if (seen >= 0 && seen < 16) begin
        word = {word[14:0], sdat};
        seen++;
      end
      data_shift_clock = 1'b0;
    end
  endtask : frameRun
endmodule : serial_reader_model

/* File: dv/adc_convert_read_control_tb.sv */
/* Testbench for the convert/read control block.
   Assumes a 200 MHz clock and a shortened conversion count. */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module adc_convert_read_control_tb;
  localparam int CONV = 50;
  logic clk = 1'b0, resetn = 1'b0, cs = 1'b1, rc = 1'b1, bsel = 1'b0, fmt = 1'b1;
  logic cont = 1'b0, pd = 1'b0, src = 1'b1, aHi = 1'b0, aLo = 1'b0;
  logic [15:0] sample = 16'h0000, obs, ex, sh, prev, word;
  logic [7:0] bus, oe, pin;
  logic busyN, hiOut, loOut, addrOe, data_shift_clock, chain;
  logic [1:0] chan, c0;
  int errors = 0, n_checks = 0, nb = 0, cyc = 0;
  logic [15:0] expQ[$];
  event got;
  assign pin = (oe & bus) | (~oe & {3'h0, src, 3'h0, chain});
  adc_convert_read_control #(.CONV_CYCLES(CONV)) dut_u (.clk(clk), .resetn(resetn),
    .data_shift_clock(data_shift_clock), .chipSelectN(cs), .readConvert(rc), .byteSelect(bsel),
    .output_format_select(fmt), .continuous_mode(cont), .power_down(pd),
    .sampleData(sample), .channel_addr_hi_in(aHi), .channel_addr_lo_in(aLo),
    .channel_addr_hi_out(hiOut), .channel_addr_lo_out(loOut), .channelAddrOe(addrOe),
    .parallelDataIn(pin), .parallel_data_bus(bus), .parallelDataOe(oe), .busyN(busyN),
    .sampleChannel(chan));
  serial_reader_model rd_u (.frame(bus[3]), .sdat(bus[1]), .data_shift_clock(data_shift_clock),
    .chain(chain), .word(word));
  // Clock and hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  // Result checker against the oldest note
  always begin
    @(got);
    ex = expQ.pop_front();
    `CHK("result", ex, obs)
  end
  // Internal-clock serial capture on the rising clock, where data has settled
  always @(posedge bus[2]) if (!fmt && !src && !busyN && oe[2]) begin
    sh = {sh[14:0], bus[1]};
    nb++;
  end
  task automatic note(input logic [15:0] v); expQ.push_back(v); endtask : note
  task automatic see(input logic [15:0] v); obs = v; ->got; #1; endtask : see
  task automatic tick(input int n); repeat (n) @(negedge clk); endtask : tick
  task automatic pins(input logic c, input logic r); @(negedge clk); cs = c; rc = r; endtask : pins
  task automatic waitBusy(input logic lvl);
    int k;
    k = 0;
    while (busyN !== lvl && k < 9000) begin
      @(negedge clk);
      k++;
    end
  endtask : waitBusy
  // Start, then a second command while busy, then wait for completion
  task automatic convert(input logic viaCs, input logic [15:0] s);
    sample = s;
    pins(viaCs, 1'b0); tick(3); pins(1'b0, 1'b0);
    tick(10); pins(1'b0, 1'b1);
    tick(4); pins(1'b0, 1'b0); tick(10); pins(1'b0, 1'b1);
    waitBusy(1'b1);
  endtask : convert
  task automatic readPar();
    logic [15:0] t;
    fmt = 1'b1; pins(1'b0, 1'b1);
    bsel = 1'b0; tick(4); t[15:8] = bus;
    bsel = 1'b1; tick(4); t[7:0] = bus;
    see(t);
  endtask : readPar
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    void'($urandom(32'he1a25a37));
    tick(16); resetn = 1'b1; tick(4);
    for (int i = 0; i < 4; i++) begin
      {aHi, aLo} = 2'($urandom);
      prev = 16'($urandom);
      convert(i[0], prev);
      note(prev); readPar();
      note({14'h0, aHi, aLo}); see({14'h0, chan});
    end
    $display("parallel test done");
    pd = 1'b1; sample = ~prev; tick(8);
    pins(1'b0, 1'b0); tick(10); pins(1'b0, 1'b1); tick(60);
    note(16'h0001); see({15'h0, busyN});
    note(prev); readPar();
    pd = 1'b0; tick(8);
    $display("power down test done");
    fmt = 1'b0; src = 1'b1; prev = 16'($urandom); convert(1'b0, prev);
    pins(1'b1, 1'b1); pins(1'b0, 1'b1); tick(4);
    rd_u.frameRun(24);
    note(prev); see(word);
    pins(1'b1, 1'b1);
    $display("external serial test done");
    src = 1'b0; nb = 0; sh = 16'h0000; convert(1'b0, 16'($urandom));
    note(prev); see(sh);
    note(16'h0010); see(16'(nb));
    note(16'h0000); see({15'h0, bus[2]});
    $display("internal serial test done");
    src = 1'b1; cont = 1'b1; pd = 1'b1; tick(8);
    note(16'h0000); see({14'h0, hiOut, loOut});
    pd = 1'b0; pins(1'b0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      waitBusy(1'b0);
      if (k == 0) c0 = {hiOut, loOut};
      note({14'h0, c0 + 2'(k)}); see({14'h0, hiOut, loOut});
      waitBusy(1'b1);
    end
    note(16'h0001); see({15'h0, addrOe});
    pins(1'b1, 1'b1); cont = 1'b0; tick(100);
    $display("continuous test done");
    conclude();
  end
endmodule : adc_convert_read_control_tb
